// *** hw/urad_defines.vh ***
// Constants for the UART register address decoder.
// Assumes inclusion by every design file of the decoder.
`ifndef URAD_DEFINES_VH
`define URAD_DEFINES_VH

// ********************************
// Addresses and select values
// ********************************
`define URAD_A_DATA 3'h0
`define URAD_A_ONE 3'h1
`define URAD_A_TWO 3'h2
`define URAD_A_LINE 3'h3
`define URAD_A_FOUR 3'h4
`define URAD_A_FIVE 3'h5
`define URAD_A_SIX 3'h6
`define URAD_A_SEVEN 3'h7
`define URAD_ENH_KEY 8'hBF
`define URAD_ZERO_DIV 8'h00
`define URAD_DL_BIT 7
`define URAD_EN_BIT 4
`define URAD_FS_BIT 6
`define URAD_GP_BIT 0
`define URAD_RST_VAL 8'h00
`define URAD_REV_VAL 8'h5A // Arbitrary value

// ********************************
// Storage indices
// ********************************
`define URAD_NREG 21
`define URAD_I_DIVLO 5'h00
`define URAD_I_DIVHI 5'h01
`define URAD_I_DIVFR 5'h02
`define URAD_I_INTEN 5'h03
`define URAD_I_LINE 5'h04
`define URAD_I_MODEM 5'h05
`define URAD_I_HDUP 5'h06
`define URAD_I_SPEC 5'h07
`define URAD_I_SCR 5'h08
`define URAD_I_EMODE 5'h09
`define URAD_I_TRIG 5'h0A
`define URAD_I_FEAT 5'h0B
`define URAD_I_ENH 5'h0C
`define URAD_I_RES1 5'h0D
`define URAD_I_RES2 5'h0E
`define URAD_I_PAU1 5'h0F
`define URAD_I_PAU2 5'h10
`define URAD_I_GINT 5'h11
`define URAD_I_G3T 5'h12
`define URAD_I_GINV 5'h13
`define URAD_I_GSEL 5'h14

// ********************************
// Read sources and write kinds
// ********************************
`define URAD_S_NONE 3'h0
`define URAD_S_STORE 3'h1
`define URAD_S_RXH 3'h2
`define URAD_S_IST 3'h3
`define URAD_S_LST 3'h4
`define URAD_S_MST 3'h5
`define URAD_S_LVL 3'h6
`define URAD_S_REV 3'h7
`define URAD_W_NONE 2'h0
`define URAD_W_STORE 2'h1
`define URAD_W_TXH 2'h2
`define URAD_W_QCTL 2'h3

`endif

// *** hw/urad_store.v ***
// Flip-flop storage for all host-writable decoder registers except the transmit and queue control pass-throughs.
// Assumes one write strobe per cycle with an already decoded index.
`timescale 1ns/1ps
`include "urad_defines.vh"

module urad_store (
    // Clock and reset
    input wire clock,
    input wire reset,
    // Write side
    input wire wr_en,
    input wire [4:0] wr_idx,
    input wire [7:0] wr_data,
    // All bytes, flattened, index 0 lowest
    output wire [8*`URAD_NREG-1:0] bytes
);

    // ********************************
    // One byte per entry
    // ********************************
    genvar i;
    generate
        for (i = 0; i < `URAD_NREG; i = i + 1) begin : g_byte
            localparam [4:0] IDX = i;
            reg [7:0] byte_r;
            // Only the addressed entry loads; others hold
            always @(posedge clock) begin
                if (reset) begin
                    byte_r <= `URAD_RST_VAL;
                end else if (wr_en && (wr_idx == IDX)) begin
                    byte_r <= wr_data;
                end
            end
            assign bytes[8*i+7:8*i] = byte_r;
        end
    endgenerate

endmodule

// *** hw/urad_rdmux.v ***
// Read data selection for the register decoder.
// Assumes the source code and index come from the decode stage.
`timescale 1ns/1ps
`include "urad_defines.vh"

module urad_rdmux (
    // Selection
    input wire [2:0] src,
    input wire [4:0] idx,
    // Candidate values
    input wire [8*`URAD_NREG-1:0] bytes,
    input wire [7:0] rxh,
    input wire [7:0] ist,
    input wire [7:0] lst,
    input wire [7:0] mst,
    input wire [7:0] lvl,
    input wire [7:0] rev,
    // Result
    output reg [7:0] data
);

    // ********************************
    // Source mux
    // ********************************
    // Write-only holes read zero, which is harmless to software
    always @* begin
        case (src)
            `URAD_S_STORE: data = bytes[8*idx +: 8];
            `URAD_S_RXH: data = rxh;
            `URAD_S_IST: data = ist;
            `URAD_S_LST: data = lst;
            `URAD_S_MST: data = mst;
            `URAD_S_LVL: data = lvl;
            `URAD_S_REV: data = rev;
            default: data = 8'h00;
        endcase
    end

endmodule

// *** hw/urad_top.v ***
// Register address decoder and register bank of a serial-bus UART.
// Assumes the bus front end delivers one-cycle read and write strobes
// with a 3-bit address, all synchronous to clock.
`timescale 1ns/1ps
`include "urad_defines.vh"

module urad_top #(
    // Arbitrary revision value
    parameter [7:0] REVISION = `URAD_REV_VAL
) (
    // Clock and reset
    input wire clock,
    input wire reset,
    // Register access port
    input wire [2:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata_r,
    output reg reg_rvalid_r,
    // Datapath status inputs
    input wire [7:0] rxh_data,
    input wire [7:0] ist_data,
    input wire [7:0] lst_data,
    input wire [7:0] mst_data,
    input wire [7:0] lvl_data,
    // Datapath side effects
    output reg rxh_pop_r,
    output reg ist_read_r,
    output reg lst_read_r,
    output reg mst_read_r,
    output reg tx_load_r,
    output reg [7:0] tx_data_r,
    output reg qctl_load_r,
    output reg [7:0] qctl_data_r,
    // Stored register contents, index order
    output wire [8*`URAD_NREG-1:0] cfg_bytes
);

    // ********************************
    // Bank selection terms
    // ********************************
    wire [7:0] line_control;
    wire [7:0] enhanced_function;
    wire [7:0] feature_control;
    wire [7:0] special_function;
    wire [7:0] divisor_low_byte;
    wire [7:0] divisor_high_byte;
    wire key_sel;
    wire divisor_latch_bit;
    wire enhanced_enable_bit;
    wire feature_select_bit;
    wire gpio_access_bit;
    wire div_zero;

    assign line_control = cfg_bytes[8*`URAD_I_LINE +: 8];
    assign enhanced_function = cfg_bytes[8*`URAD_I_ENH +: 8];
    assign feature_control = cfg_bytes[8*`URAD_I_FEAT +: 8];
    assign special_function = cfg_bytes[8*`URAD_I_SPEC +: 8];
    assign divisor_low_byte = cfg_bytes[8*`URAD_I_DIVLO +: 8];
    assign divisor_high_byte = cfg_bytes[8*`URAD_I_DIVHI +: 8];

    // Key comparison selects the enhanced bank
    assign key_sel = (line_control == `URAD_ENH_KEY);
    assign divisor_latch_bit = line_control[`URAD_DL_BIT];
    assign enhanced_enable_bit = enhanced_function[`URAD_EN_BIT];
    assign feature_select_bit = feature_control[`URAD_FS_BIT];
    assign gpio_access_bit = special_function[`URAD_GP_BIT];
    // Both divisor bytes clear unlocks the revision read
    assign div_zero = (divisor_low_byte == `URAD_ZERO_DIV) &&
                      (divisor_high_byte == `URAD_ZERO_DIV);

    // ********************************
    // Address decode
    // ********************************
    reg [2:0] rd_src_nxt;
    reg [4:0] rd_idx_nxt;
    reg [1:0] wr_kind_nxt;
    reg [4:0] wr_idx_nxt;

    // Read and write paths decoded separately since they differ per address
    always @* begin
        rd_src_nxt = `URAD_S_NONE;
        rd_idx_nxt = 5'h00;
        wr_kind_nxt = `URAD_W_NONE;
        wr_idx_nxt = 5'h00;
        case (reg_addr)
            `URAD_A_DATA: begin
                // Key value tested first: it also has the latch bit set
                if (key_sel) begin
                    // Level counter read, trigger level write
                    rd_src_nxt = `URAD_S_LVL;
                    wr_kind_nxt = `URAD_W_STORE;
                    wr_idx_nxt = `URAD_I_TRIG;
                end else if (divisor_latch_bit) begin
                    // Revision shows only while the divisor is unprogrammed
                    if (div_zero) begin
                        rd_src_nxt = `URAD_S_REV;
                    end else begin
                        rd_src_nxt = `URAD_S_STORE;
                        rd_idx_nxt = `URAD_I_DIVLO;
                    end
                    // Writes always reach the low byte, else it could never leave zero
                    wr_kind_nxt = `URAD_W_STORE;
                    wr_idx_nxt = `URAD_I_DIVLO;
                end else begin
                    // Data path: both directions go to the datapath, not storage
                    rd_src_nxt = `URAD_S_RXH;
                    wr_kind_nxt = `URAD_W_TXH;
                end
            end
            `URAD_A_ONE: begin
                // Every bank has a plain read/write byte here
                rd_src_nxt = `URAD_S_STORE;
                wr_kind_nxt = `URAD_W_STORE;
                if (key_sel) begin
                    rd_idx_nxt = `URAD_I_FEAT;
                    wr_idx_nxt = `URAD_I_FEAT;
                end else if (divisor_latch_bit) begin
                    // Fraction bits do not gate this; the baud logic interprets them
                    rd_idx_nxt = `URAD_I_DIVHI;
                    wr_idx_nxt = `URAD_I_DIVHI;
                end else begin
                    rd_idx_nxt = `URAD_I_INTEN;
                    wr_idx_nxt = `URAD_I_INTEN;
                end
            end
            `URAD_A_TWO: begin
                if (key_sel) begin
                    rd_src_nxt = `URAD_S_STORE;
                    rd_idx_nxt = `URAD_I_ENH;
                    wr_kind_nxt = `URAD_W_STORE;
                    wr_idx_nxt = `URAD_I_ENH;
                end else if (divisor_latch_bit && enhanced_enable_bit) begin
                    // Fraction byte hidden until enhanced functions are on
                    rd_src_nxt = `URAD_S_STORE;
                    rd_idx_nxt = `URAD_I_DIVFR;
                    wr_kind_nxt = `URAD_W_STORE;
                    wr_idx_nxt = `URAD_I_DIVFR;
                end else begin
                    // Latch clear, or enhanced off with non-key value
                    rd_src_nxt = `URAD_S_IST;
                    wr_kind_nxt = `URAD_W_QCTL;
                end
            end
            `URAD_A_LINE: begin
                // Always reachable so software can leave any bank
                rd_src_nxt = `URAD_S_STORE;
                rd_idx_nxt = `URAD_I_LINE;
                wr_kind_nxt = `URAD_W_STORE;
                wr_idx_nxt = `URAD_I_LINE;
            end
            `URAD_A_FOUR: begin
                // Read/write in all three banks, only the target differs
                rd_src_nxt = `URAD_S_STORE;
                wr_kind_nxt = `URAD_W_STORE;
                if (!key_sel) begin
                    rd_idx_nxt = `URAD_I_MODEM;
                    wr_idx_nxt = `URAD_I_MODEM;
                end else if (gpio_access_bit) begin
                    rd_idx_nxt = `URAD_I_GINT;
                    wr_idx_nxt = `URAD_I_GINT;
                end else begin
                    rd_idx_nxt = `URAD_I_RES1;
                    wr_idx_nxt = `URAD_I_RES1;
                end
            end
            `URAD_A_FIVE: begin
                if (!key_sel) begin
                    // Status read and setup write share the address
                    rd_src_nxt = `URAD_S_LST;
                    wr_kind_nxt = `URAD_W_STORE;
                    wr_idx_nxt = `URAD_I_HDUP;
                end else begin
                    rd_src_nxt = `URAD_S_STORE;
                    wr_kind_nxt = `URAD_W_STORE;
                    rd_idx_nxt = gpio_access_bit ? `URAD_I_G3T : `URAD_I_RES2;
                    wr_idx_nxt = gpio_access_bit ? `URAD_I_G3T : `URAD_I_RES2;
                end
            end
            `URAD_A_SIX: begin
                if (!key_sel) begin
                    rd_src_nxt = `URAD_S_MST;
                    // Without the enable bit the write is silently dropped
                    if (enhanced_enable_bit) begin
                        wr_kind_nxt = `URAD_W_STORE;
                        wr_idx_nxt = `URAD_I_SPEC;
                    end
                end else begin
                    rd_src_nxt = `URAD_S_STORE;
                    wr_kind_nxt = `URAD_W_STORE;
                    rd_idx_nxt = gpio_access_bit ? `URAD_I_GINV : `URAD_I_PAU1;
                    wr_idx_nxt = gpio_access_bit ? `URAD_I_GINV : `URAD_I_PAU1;
                end
            end
            `URAD_A_SEVEN: begin
                if (key_sel) begin
                    rd_src_nxt = `URAD_S_STORE;
                    wr_kind_nxt = `URAD_W_STORE;
                    rd_idx_nxt = gpio_access_bit ? `URAD_I_GSEL : `URAD_I_PAU2;
                    wr_idx_nxt = gpio_access_bit ? `URAD_I_GSEL : `URAD_I_PAU2;
                end else if (gpio_access_bit || feature_select_bit) begin
                    // Counter read where nothing readable is mapped
                    rd_src_nxt = `URAD_S_LVL;
                    // Gpio access hides the mode select; write is dropped then
                    if (!gpio_access_bit) begin
                        wr_kind_nxt = `URAD_W_STORE;
                        wr_idx_nxt = `URAD_I_EMODE;
                    end
                end else begin
                    // Scratch byte: pure storage, no side effect anywhere
                    rd_src_nxt = `URAD_S_STORE;
                    rd_idx_nxt = `URAD_I_SCR;
                    wr_kind_nxt = `URAD_W_STORE;
                    wr_idx_nxt = `URAD_I_SCR;
                end
            end
            default: begin
                rd_src_nxt = `URAD_S_NONE;
            end
        endcase
    end

    // ********************************
    // Storage and read mux
    // ********************************
    wire store_wr;
    wire [7:0] rd_value;

    // Only decoded store targets load; read-only holes are dropped
    assign store_wr = reg_wr && (wr_kind_nxt == `URAD_W_STORE);

    urad_store u_store (
        .clock(clock),
        .reset(reset),
        .wr_en(store_wr),
        .wr_idx(wr_idx_nxt),
        .wr_data(reg_wdata),
        .bytes(cfg_bytes)
    );

    urad_rdmux u_rdmux (
        .src(rd_src_nxt),
        .idx(rd_idx_nxt),
        .bytes(cfg_bytes),
        .rxh(rxh_data),
        .ist(ist_data),
        .lst(lst_data),
        .mst(mst_data),
        .lvl(lvl_data),
        .rev(REVISION),
        .data(rd_value)
    );

    // ********************************
    // Read answer
    // ********************************
    // Decode uses bank state before any write in the same cycle
    always @(posedge clock) begin
        if (reset) begin
            reg_rdata_r <= 8'h00;
            reg_rvalid_r <= 1'b0;
        end else begin
            reg_rvalid_r <= reg_rd;
            if (reg_rd) begin
                reg_rdata_r <= rd_value;
            end
        end
    end

    // ********************************
    // Read side effects
    // ********************************
    // Pulses let the datapath pop the queue or clear deltas
    always @(posedge clock) begin
        if (reset) begin
            rxh_pop_r <= 1'b0;
            ist_read_r <= 1'b0;
            lst_read_r <= 1'b0;
            mst_read_r <= 1'b0;
        end else begin
            rxh_pop_r <= reg_rd && (rd_src_nxt == `URAD_S_RXH);
            ist_read_r <= reg_rd && (rd_src_nxt == `URAD_S_IST);
            lst_read_r <= reg_rd && (rd_src_nxt == `URAD_S_LST);
            mst_read_r <= reg_rd && (rd_src_nxt == `URAD_S_MST);
        end
    end

    // ********************************
    // Write-only pass-through targets
    // ********************************
    // Data held after the pulse so the datapath may sample late
    always @(posedge clock) begin
        if (reset) begin
            tx_load_r <= 1'b0;
            tx_data_r <= 8'h00;
            qctl_load_r <= 1'b0;
            qctl_data_r <= 8'h00;
        end else begin
            tx_load_r <= reg_wr && (wr_kind_nxt == `URAD_W_TXH);
            qctl_load_r <= reg_wr && (wr_kind_nxt == `URAD_W_QCTL);
            if (reg_wr && (wr_kind_nxt == `URAD_W_TXH)) begin
                tx_data_r <= reg_wdata;
            end
            if (reg_wr && (wr_kind_nxt == `URAD_W_QCTL)) begin
                qctl_data_r <= reg_wdata;
            end
        end
    end

endmodule

// *** verification/urad_dp_model.sv ***
// Datapath stand-in that feeds status values to the register decoder.
// Assumes the decoder pulses rxh_pop_r for one cycle per receive read.
`timescale 1ns/1ps

module urad_dp_model (
    // Clock and reset
    input wire clock,
    input wire reset,
    // Pulse from the decoder
    input wire rxh_pop_r,
    // Datapath values
    output reg [7:0] rxh_data,
    output wire [7:0] ist_data,
    output wire [7:0] lst_data,
    output wire [7:0] mst_data,
    output wire [7:0] lvl_data
);
    // ********************************
    // Receive queue
    // ********************************
    // Next byte after each pop, so a missed or doubled pop shows up
    always @(posedge clock) begin
        if (reset) begin
            rxh_data <= 8'h41;
        end else if (rxh_pop_r) begin
            rxh_data <= rxh_data + 8'h01;
        end
    end

    // Fixed status values, distinct so a wrong source is visible
    assign ist_data = 8'hC1;
    assign lst_data = 8'h60;
    assign mst_data = 8'hB0;
    assign lvl_data = 8'h33;
endmodule

// *** verification/urad_top_chk.sv ***
// Concurrent checks on the register decoder ports.
// Assumes storage index order of the defines header.
`timescale 1ns/1ps
`include "urad_defines.vh"

module urad_top_chk (
    // Clock and reset
    input wire clock,
    input wire reset,
    // Register port
    input wire [2:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata_r,
    input wire reg_rvalid_r,
    // Datapath
    input wire [7:0] rxh_data,
    input wire [7:0] lst_data,
    input wire rxh_pop_r,
    input wire lst_read_r,
    input wire tx_load_r,
    input wire [7:0] tx_data_r,
    input wire qctl_load_r,
    input wire [7:0] qctl_data_r,
    input wire [8*`URAD_NREG-1:0] cfg_bytes
);
    // ********************************
    // Helpers and assertions
    // ********************************
    // Views of the bank-select bytes
    wire [7:0] line_ctl = cfg_bytes[39:32];
    wire [7:0] enh_fn = cfg_bytes[103:96];
    wire nkey = (line_ctl != 8'hBF);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    chk_rvalid_after_rd: assert property (reg_rd |=> reg_rvalid_r)
        else $error("read without valid");
    chk_rvalid_no_rd: assert property (!reg_rd |=> !reg_rvalid_r)
        else $error("valid without read");
    chk_tx_load: assert property (reg_wr && reg_addr == 3'h0 && !line_ctl[7] |=>
        tx_load_r && tx_data_r == $past(reg_wdata)) else $error("transmit load wrong");
    chk_rx_read: assert property (reg_rd && reg_addr == 3'h0 && !line_ctl[7] |=>
        rxh_pop_r && reg_rdata_r == $past(rxh_data)) else $error("receive read wrong");
    chk_line_write: assert property (reg_wr && reg_addr == 3'h3 |=> line_ctl == $past(reg_wdata))
        else $error("line control write lost");
    chk_line_read: assert property (reg_rd && reg_addr == 3'h3 |=> reg_rdata_r == $past(line_ctl))
        else $error("line control read wrong");
    chk_status_read: assert property (reg_rd && reg_addr == 3'h5 && nkey |=>
        lst_read_r && reg_rdata_r == $past(lst_data)) else $error("line status read wrong");
    chk_qctl_load: assert property (reg_wr && reg_addr == 3'h2 && nkey && (!line_ctl[7] || !enh_fn[4]) |=>
        qctl_load_r && qctl_data_r == $past(reg_wdata)) else $error("queue control load wrong");
    chk_trg_write: assert property (reg_wr && reg_addr == 3'h0 && !nkey |=>
        cfg_bytes[87:80] == $past(reg_wdata) && !tx_load_r) else $error("trigger write wrong");

    cov_enh_write: cover property (reg_wr && !nkey);
    cov_div_read: cover property (reg_rd && line_ctl == 8'h80);
    cov_back_to_back: cover property (reg_rd ##1 reg_rd);
endmodule

bind urad_top urad_top_chk u_urad_top_chk (.clock(clock), .reset(reset), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
    .reg_rvalid_r(reg_rvalid_r), .rxh_data(rxh_data), .lst_data(lst_data), .rxh_pop_r(rxh_pop_r),
    .lst_read_r(lst_read_r), .tx_load_r(tx_load_r), .tx_data_r(tx_data_r),
    .qctl_load_r(qctl_load_r), .qctl_data_r(qctl_data_r), .cfg_bytes(cfg_bytes));

// *** verification/uart_register_address_decode_tb_top.sv ***
// Directed bench for the register decoder, walking every bank state.
// Assumes the datapath model and the checker file compiled before.
`timescale 1ns/1ps
`include "urad_defines.vh"
`define CHK(g, e) begin cmp_count = cmp_count + 1; if ((g) !== (e)) begin num_errors = num_errors + 1; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end

module uart_register_address_decode_tb_top;
    // ********************************
    // Signals
    // ********************************
    reg clock = 1'b0;
    reg reset = 1'b1;
    reg [2:0] reg_addr = 3'h0;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg [7:0] reg_wdata = 8'h00;
    wire [7:0] reg_rdata_r, rxh_data, ist_data, lst_data, mst_data, lvl_data, tx_data_r, qctl_data_r;
    wire reg_rvalid_r, rxh_pop_r, ist_read_r, lst_read_r, mst_read_r, tx_load_r, qctl_load_r;
    wire [8*`URAD_NREG-1:0] cfg_bytes;
    integer num_errors = 0;
    integer cmp_count = 0;
    integer i;

    // 10 MHz clock
    always #50 clock = ~clock;

    urad_top u_urad_top (.clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r), .reg_rvalid_r(reg_rvalid_r),
        .rxh_data(rxh_data), .ist_data(ist_data), .lst_data(lst_data), .mst_data(mst_data),
        .lvl_data(lvl_data), .rxh_pop_r(rxh_pop_r), .ist_read_r(ist_read_r), .lst_read_r(lst_read_r),
        .mst_read_r(mst_read_r), .tx_load_r(tx_load_r), .tx_data_r(tx_data_r), .qctl_load_r(qctl_load_r),
        .qctl_data_r(qctl_data_r), .cfg_bytes(cfg_bytes));
    urad_dp_model u_urad_dp_model (.clock(clock), .reset(reset), .rxh_pop_r(rxh_pop_r),
        .rxh_data(rxh_data), .ist_data(ist_data), .lst_data(lst_data), .mst_data(mst_data),
        .lvl_data(lvl_data));

    // ********************************
    // Access tasks
    // ********************************
    // One-cycle strobe; the idle edge first keeps two calls' strobes apart
    // and lets the receive model advance after a pop before the next read
    task wr(input [2:0] a, input [7:0] d);
        begin
            @(negedge clock);
            reg_addr = a;
            reg_wdata = d;
            reg_wr = 1'b1;
            @(negedge clock);
            reg_wr = 1'b0;
        end
    endtask

    // Answer lands one edge later, sampled mid-cycle while valid stands
    task rdc(input [2:0] a, input [7:0] e);
        begin
            @(negedge clock);
            reg_addr = a;
            reg_rd = 1'b1;
            @(negedge clock);
            reg_rd = 1'b0;
            `CHK(reg_rvalid_r, 1'b1)
            `CHK(reg_rdata_r, e)
        end
    endtask

    task byt(input integer k, input [7:0] e);
        `CHK(cfg_bytes[8*k +: 8], e)
    endtask

    task tend(input [8*12-1:0] name);
        $display("test %0s done", name);
    endtask

    task test_done;
        begin
            $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
            if (num_errors == 0 && cmp_count > 0) begin
                $display("Test passed");
            end else begin
                $display("Test failed");
            end
            $finish;
        end
    endtask

    // Watchdog, far beyond the directed sequence
    initial begin
        #(100 * 5000);
        num_errors = num_errors + 1;
        test_done;
    end

    // ********************************
    // Main sequence
    // ********************************
    initial begin
        repeat (20) @(negedge clock);
        reset = 1'b0;
        rdc(3'h3, 8'h00);
        rdc(3'h0, 8'h41);
        `CHK(rxh_pop_r, 1'b1)
        rdc(3'h0, 8'h42);
        wr(3'h0, 8'hA5);
        `CHK(tx_load_r, 1'b1)
        `CHK(tx_data_r, 8'hA5)
        wr(3'h1, 8'h0F);
        rdc(3'h1, 8'h0F);
        wr(3'h4, 8'h13);
        rdc(3'h4, 8'h13);
        rdc(3'h5, 8'h60);
        `CHK(lst_read_r, 1'b1)
        rdc(3'h6, 8'hB0);
        `CHK(mst_read_r, 1'b1)
        wr(3'h5, 8'h77);
        byt(6, 8'h77);
        wr(3'h2, 8'hC7);
        `CHK(qctl_load_r, 1'b1)
        `CHK(qctl_data_r, 8'hC7)
        rdc(3'h2, 8'hC1);
        `CHK(ist_read_r, 1'b1)
        `CHK(rxh_pop_r, 1'b0)
        wr(3'h6, 8'h55);
        byt(7, 8'h00);
        wr(3'h7, 8'h9C);
        rdc(3'h7, 8'h9C);
        tend("normal");
        wr(3'h3, 8'h80);
        rdc(3'h0, `URAD_REV_VAL);
        wr(3'h0, 8'h12);
        rdc(3'h0, 8'h12);
        wr(3'h1, 8'h34);
        rdc(3'h1, 8'h34);
        rdc(3'h2, 8'hC1);
        rdc(3'h3, 8'h80);
        tend("divisor");
        // Host opens the enhanced bank with the key value
        wr(3'h3, 8'hBF);
        wr(3'h2, 8'h10);
        rdc(3'h2, 8'h10);
        wr(3'h1, 8'h40);
        rdc(3'h1, 8'h40);
        wr(3'h0, 8'h3A);
        byt(10, 8'h3A);
        byt(0, 8'h12);
        rdc(3'h0, 8'h33);
        for (i = 4; i < 8; i = i + 1) begin
            wr(i[2:0], 8'h20 + i[7:0]);
        end
        for (i = 4; i < 8; i = i + 1) begin
            rdc(i[2:0], 8'h20 + i[7:0]);
        end
        tend("enhanced");
        wr(3'h3, 8'h80);
        wr(3'h2, 8'h66);
        rdc(3'h2, 8'h66);
        rdc(3'h0, 8'h12);
        // Leaving the key value restores the normal bank
        wr(3'h3, 8'h03);
        wr(3'h7, 8'hE1);
        byt(9, 8'hE1);
        rdc(3'h7, 8'h33);
        wr(3'h6, 8'h01);
        byt(7, 8'h01);
        wr(3'h7, 8'h99);
        byt(9, 8'hE1);
        wr(3'h3, 8'hBF);
        for (i = 4; i < 8; i = i + 1) begin
            wr(i[2:0], 8'h50 + i[7:0]);
        end
        for (i = 4; i < 8; i = i + 1) begin
            rdc(i[2:0], 8'h50 + i[7:0]);
        end
        byt(13, 8'h24);
        tend("gpio");
        // Second reset in mid-run returns to the normal bank
        reset = 1'b1;
        @(negedge clock);
        reset = 1'b0;
        rdc(3'h3, 8'h00);
        byt(12, 8'h00);
        tend("rereset");
        test_done;
    end
endmodule
